// File: tb/dps_master.sv
// Fieldbus master model: 16-bit reads and writes, 32-bit values as pairs.
// Assumes ack, data and err one cycle after each strobe.
`timescale 1ns/10ps
module dps_master
(
  // Clock
  input wire clk,
  // Requests
  output reg bus_wr,
  output reg bus_rd,
  output reg [15:0] bus_addr,
  output reg [15:0] bus_wdata,
  // Answer
  input wire [15:0] bus_rdata_q,
  input wire bus_err_q
);
  initial
  begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
  end
  task access(input w, input [15:0] a, input [15:0] d, output [15:0] r, output e);
  begin
    @(posedge clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    // Released lines toggle so a stale value never looks valid
    bus_addr <= ~a;
    bus_wdata <= ~d;
    // Answer taken at the edge where ack is sampled high
    @(posedge clk);
    r = bus_rdata_q;
    e = bus_err_q;
  end
  endtask
  // High half first; the low half commits the value
  task access32(input w, input [15:0] a, input [31:0] d, output [31:0] r, output e);
    reg e1;
  begin
    access(w, a, d[31:16], r[31:16], e1);
    access(w, a + 16'h0001, d[15:0], r[15:0], e);
    e = e | e1;
  end
  endtask
endmodule // dps_master

// File: tb/dps_params_sva.sv
// Concurrent checks on the ports of the position scaling parameter block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module dps_params_sva
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fieldbus access
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_addr,
  input wire bus_ack_q,
  input wire bus_err_q,
  // Motion values
  input wire dir_ccw_q,
  input wire [31:0] scale_num_q,
  input wire [31:0] scale_denom_q,
  input wire [46:0] scale_factor_q,
  input wire factor_valid_q,
  input wire [31:0] user_limit_q,
  input wire [31:0] pp_speed_eff_q,
  input wire rel_ref_actual_q
);
  wire num_lo = bus_wr && bus_addr == 16'h0611;
  wire opt_wr = bus_wr && bus_addr == 16'h1B30;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ack_after_req: assert property ((bus_wr || bus_rd) |=> bus_ack_q)
    else $error("ack missing");
  a_ack_needs_req: assert property (bus_ack_q |-> $past(bus_wr || bus_rd))
    else $error("ack without request");
  a_err_with_ack: assert property (bus_err_q |-> bus_ack_q)
    else $error("err without ack");
  a_dir_power_up: assert property ($changed(dir_ccw_q) |-> $past(reset) || $past(reset, 2))
    else $error("direction moved in run");
  a_denom_in_range: assert property (scale_denom_q != 32'h0 && !scale_denom_q[31])
    else $error("denominator out of range");
  a_num_in_range: assert property (scale_num_q != 32'h0 && !scale_num_q[31])
    else $error("numerator out of range");
  a_pair_on_num: assert property (($changed(scale_num_q) || $changed(scale_denom_q)) |->
    $past(num_lo) || $past(num_lo, 2) || $past(num_lo, 3)) else $error("scale moved");
  a_factor_holds: assert property (factor_valid_q && $past(factor_valid_q) |->
    $stable(scale_factor_q)) else $error("factor moved while valid");
  a_limit_codes: assert property (user_limit_q == 32'h7FFFFFFF || user_limit_q == 32'h3FFFFFFF)
    else $error("bad user limit");
  a_speed_min: assert property (pp_speed_eff_q != 32'h0)
    else $error("speed below one");
  a_opt_on_write: assert property ($changed(rel_ref_actual_q) |-> $past(opt_wr) ||
    $past(opt_wr, 2)) else $error("option moved");
  c_num_commit: cover property (num_lo);
  c_refused: cover property (bus_err_q);
  c_factor_done: cover property ($rose(factor_valid_q));
endmodule // dps_params_sva

bind dps_params dps_params_sva dps_params_sva_i (.clk, .reset, .bus_wr, .bus_rd, .bus_addr,
  .bus_ack_q, .bus_err_q, .dir_ccw_q, .scale_num_q, .scale_denom_q, .scale_factor_q,
  .factor_valid_q, .user_limit_q, .pp_speed_eff_q, .rel_ref_actual_q);

// File: tb/dps_params_test.sv
// Self-checking bench for the position scaling parameter block.
// Assumes the master model drives the bus; seeded random scaling pairs.
`timescale 1ns/10ps
`include "dps_regs.vh"
module dps_params_test;
  reg clk;
  reg reset;
  wire bus_wr;
  wire bus_rd;
  wire [15:0] bus_addr;
  wire [15:0] bus_wdata;
  wire [15:0] bus_rdata_q;
  wire bus_ack_q;
  wire bus_err_q;
  wire dir_ccw_q;
  wire [31:0] scale_num_q;
  wire [31:0] scale_denom_q;
  wire [46:0] scale_factor_q;
  wire factor_valid_q;
  wire [31:0] user_limit_q;
  wire [31:0] pp_speed_eff_q;
  wire rel_ref_actual_q;
  integer failures;
  integer samples_checked;
  integer seed;
  integer i;
  reg [31:0] v;
  reg [31:0] n;
  reg [31:0] d;
  reg [31:0] pd;
  reg [15:0] r;
  reg e;
  reg rel;
  dps_master dps_master_i (.clk(clk), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .bus_err_q(bus_err_q));
  dps_params dps_params_i (.clk(clk), .reset(reset), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .bus_ack_q(bus_ack_q), .bus_err_q(bus_err_q), .dir_ccw_q(dir_ccw_q),
    .scale_num_q(scale_num_q), .scale_denom_q(scale_denom_q), .scale_factor_q(scale_factor_q),
    .factor_valid_q(factor_valid_q), .user_limit_q(user_limit_q),
    .pp_speed_eff_q(pp_speed_eff_q), .rel_ref_actual_q(rel_ref_actual_q));
  function [46:0] exp_factor(input [31:0] nu, input [31:0] de);
    exp_factor = ({15'h0, nu} << `DPS_FACTOR_SHIFT) / de;
  endfunction
  task check(input [46:0] got, input [46:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Divider needs time to drop valid, then finish
  task wait_factor;
  begin
    repeat (8) if (factor_valid_q === 1'b1) @(posedge clk);
    repeat (100) if (factor_valid_q !== 1'b1) @(posedge clk);
    #1;
    check(factor_valid_q, 1'b1);
  end
  endtask
  task settle;
  begin
    repeat (2) @(posedge clk);
    #1;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #2000000;
    failures = failures + 1;
    give_verdict;
  end
  initial
  begin
    seed = 32'h61bda2b6;
    failures = 0;
    samples_checked = 0;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wait_factor;
    dps_master_i.access32(1'b0, `DPS_ADDR_DENOM, 32'h0, v, e);
    check(v, `DPS_RST_DENOM);
    dps_master_i.access32(1'b0, `DPS_ADDR_NUM, 32'h0, v, e);
    check(v, `DPS_RST_NUM);
    dps_master_i.access32(1'b0, `DPS_ADDR_PPSPD, 32'h0, v, e);
    check(v, `DPS_RST_PPSPD);
    dps_master_i.access(1'b0, `DPS_ADDR_PPOPT, 16'h0, r, e);
    check(r, `DPS_RST_PPOPT);
    dps_master_i.access(1'b0, 16'h0700, 16'h0, r, e);
    check(e, 1'b1);
    check(user_limit_q, 32'h7FFFFFFF);
    check(scale_factor_q, exp_factor(`DPS_RST_NUM, `DPS_RST_DENOM));
    dps_master_i.access(1'b0, `DPS_ADDR_DIR, 16'h0, r, e);
    check({dir_ccw_q, r}, {1'b0, `DPS_RST_DIR});
    dps_master_i.access(1'b1, `DPS_ADDR_DIR, 16'h0002, r, e);
    check(e, 1'b1);
    dps_master_i.access(1'b1, `DPS_ADDR_DIR, 16'h0001, r, e);
    dps_master_i.access(1'b0, `DPS_ADDR_DIR, 16'h0, r, e);
    settle;
    check({dir_ccw_q, r}, {1'b0, 16'h0001});
    rel = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      dps_master_i.access(1'b1, `DPS_ADDR_PPOPT, i, r, e);
      check(e, i == 1 || i == 3);
      rel = (i == 0 || i == 2) ? i == 2 : rel;
      settle;
      check(rel_ref_actual_q, rel);
    end
    dps_master_i.access32(1'b1, `DPS_ADDR_DENOM, 32'h0, v, e);
    check(e, 1'b1);
    pd = `DPS_RST_DENOM;
    for (i = 0; i < 5; i = i + 1)
    begin
      n = (i == 4) ? 32'h7FFFFFFF : ($random(seed) & 32'hFFFF) + 1;
      d = (i == 4) ? 32'h1 : ($random(seed) & 32'h7FFFFFFF) | 32'h1;
      dps_master_i.access32(1'b1, `DPS_ADDR_DENOM, d, v, e);
      settle;
      check(scale_denom_q, pd);
      dps_master_i.access32(1'b1, `DPS_ADDR_NUM, n, v, e);
      wait_factor;
      check(scale_num_q, n);
      check(scale_denom_q, d);
      check(scale_factor_q, exp_factor(n, d));
      v = exp_factor(n, d) >> 32;
      check(user_limit_q, v == 0 ? 32'h7FFFFFFF : 32'h3FFFFFFF);
      dps_master_i.access(1'b0, `DPS_ADDR_NMAX + 16'h0001, 16'h0, r, e);
      check(r, v == 0 ? 16'h7FFF : 16'h3FFF);
      pd = d;
    end
    dps_master_i.access32(1'b1, `DPS_ADDR_NUM, 32'h80000000, v, e);
    wait_factor;
    check(scale_num_q, 32'h7FFFFFFF);
    dps_master_i.access(1'b0, `DPS_ADDR_NMAX, 16'h0, r, e);
    check(r, `DPS_RST_NMAX);
    dps_master_i.access32(1'b1, `DPS_ADDR_PPSPD, 32'd5000, v, e);
    settle;
    check(pp_speed_eff_q, `DPS_RST_NMAX);
    dps_master_i.access(1'b1, `DPS_ADDR_NMAX, 16'd50, r, e);
    settle;
    check(pp_speed_eff_q, 32'd50);
    dps_master_i.access32(1'b1, `DPS_ADDR_PPSPD, 32'd20, v, e);
    settle;
    check(pp_speed_eff_q, 32'd20);
    give_verdict;
  end
endmodule // dps_params_test

// File: verilog/dps_params.v
// Position scaling and profile position parameter block.
// Assumes a fieldbus front end presenting 16-bit register reads and writes
// on clk; reset is the power-up reset of the drive.
//
// Notes on behaviour
// - Direction defaults 0; 0 clockwise, 1 counter-clockwise at positive speed.
// - Written direction stored; motion keeps old direction until next power-up; reset clears dir_q first, so a written direction never reaches motion.
// - Denominator signed 32-bit, range 1 to 2147483647, default 16384.
// - Numerator signed 32-bit, range 1 to 2147483647, default 1.
// - New scaling pair applied only on numerator write; master writes denominator first.
// - Factor equals numerator revolutions divided by denominator user units.
// - Internal factor may narrow user limits; reported ranges show the reduction.
// - Profile speed unsigned 32-bit, minimum 1, default 60, clamped to limit.
// - Relative option defaults 0; 0 previous target, 2 actual, 1 unsupported.
// - Reference speed above maximum speed limit is reduced to that limit.
`timescale 1ns/10ps
`include "dps_regs.vh"
module dps_params
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fieldbus register access
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_addr,
  input wire [15:0] bus_wdata,
  output reg [15:0] bus_rdata_q,
  output reg bus_ack_q,
  output reg bus_err_q,
  // Values used by motion logic
  output reg dir_ccw_q,
  output reg [31:0] scale_num_q,
  output reg [31:0] scale_denom_q,
  output reg [46:0] scale_factor_q,
  output reg factor_valid_q,
  output reg [31:0] user_limit_q,
  output reg [31:0] pp_speed_eff_q,
  output reg rel_ref_actual_q
);
  reg [15:0] dir_q;
  reg [15:0] opt_q;
  reg [15:0] nmax_q;
  reg [31:0] denom_stage_q;
  reg [15:0] rd_hi_q;
  reg init_q;
  reg [15:0] denom_hi_q;
  wire [31:0] denom_raw;
  wire denom_done;
  wire [31:0] num_raw;
  wire num_done;
  wire [31:0] spd_raw;
  wire spd_done;
  wire [46:0] quot;
  wire div_busy;
  wire div_done;
  wire denom_lo_bad;
  wire num_ok;
  wire [15:0] hi_addr;
  reg [31:0] rd_word;
  reg rd_hit;
  reg rd_pair;

  // 32-bit values assembled from two halves each
  dps_word_pair #(.BASE(`DPS_ADDR_DENOM), .RST(`DPS_RST_DENOM)) u_denom
  (
    .clk(clk),
    .reset(reset),
    .wr(bus_wr),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .value_q(denom_raw),
    .done_q(denom_done)
  );

  dps_word_pair #(.BASE(`DPS_ADDR_NUM), .RST(`DPS_RST_NUM)) u_num
  (
    .clk(clk),
    .reset(reset),
    .wr(bus_wr),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .value_q(num_raw),
    .done_q(num_done)
  );

  dps_word_pair #(.BASE(`DPS_ADDR_PPSPD), .RST(`DPS_RST_PPSPD)) u_spd
  (
    .clk(clk),
    .reset(reset),
    .wr(bus_wr),
    .addr(bus_addr),
    .wdata(bus_wdata),
    .value_q(spd_raw),
    .done_q(spd_done)
  );

  // One division per accepted numerator; the factor is never seen half done
  dps_scale_div u_div
  (
    .clk(clk),
    .reset(reset),
    .start(init_q),
    .dividend({15'h0000, scale_num_q} << `DPS_FACTOR_SHIFT),
    .divisor(scale_denom_q),
    .quot_q(quot),
    .busy_q(div_busy),
    .done_q(div_done)
  );

  // Pairs sit at even bases, so the odd address maps onto its base
  assign hi_addr = {bus_addr[15:1], 1'b0};
  assign denom_lo_bad = (bus_addr == `DPS_ADDR_DENOM + 16'h0001) &&
    (denom_hi_q[15] || {denom_hi_q, bus_wdata} < `DPS_MIN_POS32);
  // Only an accepted numerator moves the pair and restarts the divider
  assign num_ok = num_done && num_raw >= `DPS_MIN_POS32 && num_raw <= `DPS_MAX_POS32 &&
    !div_busy;

  // Read decode; the high half latches the low for a coherent pair
  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    rd_pair = 1'b1;
    if (hi_addr == `DPS_ADDR_DENOM)
      rd_word = scale_denom_q;
    else if (hi_addr == `DPS_ADDR_NUM)
      rd_word = scale_num_q;
    else if (hi_addr == `DPS_ADDR_PPSPD)
      rd_word = spd_raw;
    else if (bus_addr == `DPS_ADDR_DIR)
    begin
      rd_word = {16'h0000, dir_q};
      rd_pair = 1'b0;
    end
    else if (bus_addr == `DPS_ADDR_PPOPT)
    begin
      rd_word = {16'h0000, opt_q};
      rd_pair = 1'b0;
    end
    else if (bus_addr == `DPS_ADDR_NMAX)
    begin
      rd_word = {16'h0000, nmax_q};
      rd_pair = 1'b0;
    end
    else if (bus_addr == `DPS_ADDR_NMAX + 16'h0001)
    begin
      // Reported user limit, narrowed by the internal factor
      rd_word = {16'h0000, user_limit_q[31:16]};
      rd_pair = 1'b0;
    end
    else
      rd_hit = 1'b0;
  end

  // Bus answer, one cycle after the strobe
  always @(posedge clk)
  begin
    if (reset)
    begin
      bus_rdata_q <= 16'h0000;
      bus_ack_q <= 1'b0;
      bus_err_q <= 1'b0;
      rd_hi_q <= 16'h0000;
      denom_hi_q <= 16'h0000;
    end
    else
    begin
      bus_ack_q <= bus_rd || bus_wr;
      bus_err_q <= 1'b0;
      if (bus_rd)
      begin
        if (!rd_hit)
        begin
          bus_rdata_q <= 16'h0000;
          bus_err_q <= 1'b1;
        end
        else if (!rd_pair)
          bus_rdata_q <= rd_word[15:0];
        else if (!bus_addr[0])
        begin
          bus_rdata_q <= rd_word[31:16];
          rd_hi_q <= rd_word[15:0];
        end
        else
          bus_rdata_q <= rd_hi_q;
      end
      else if (bus_wr)
      begin
        // Out of range direction, option and denominator values are refused and flagged
        if (bus_addr == `DPS_ADDR_DIR && bus_wdata > `DPS_DIR_MAX)
          bus_err_q <= 1'b1;
        else if (bus_addr == `DPS_ADDR_PPOPT && bus_wdata == `DPS_OPT_UNSUP)
          bus_err_q <= 1'b1;
        else if (bus_addr == `DPS_ADDR_PPOPT && bus_wdata > `DPS_OPT_ACT)
          bus_err_q <= 1'b1;
        // Numerator refusals stay silent; only the denominator pair is judged
        else if (denom_lo_bad)
          bus_err_q <= 1'b1;
      end
      // High half mirrored so the pair is judged at its low write
      if (bus_wr && bus_addr == `DPS_ADDR_DENOM)
        denom_hi_q <= bus_wdata;
    end
  end

  // Parameter storage
  always @(posedge clk)
  begin
    if (reset)
    begin
      dir_q <= `DPS_RST_DIR;
      opt_q <= `DPS_RST_PPOPT;
      nmax_q <= `DPS_RST_NMAX;
      denom_stage_q <= `DPS_RST_DENOM;
      scale_denom_q <= `DPS_RST_DENOM;
      scale_num_q <= `DPS_RST_NUM;
    end
    else
    begin
      if (bus_wr && bus_addr == `DPS_ADDR_DIR && bus_wdata <= `DPS_DIR_MAX)
        dir_q <= bus_wdata;
      if (bus_wr && bus_addr == `DPS_ADDR_PPOPT &&
          (bus_wdata == `DPS_OPT_PREV || bus_wdata == `DPS_OPT_ACT))
        opt_q <= bus_wdata;
      // Zero limit refused: it would stall every profile move
      if (bus_wr && bus_addr == `DPS_ADDR_NMAX && bus_wdata != 16'h0000)
        nmax_q <= bus_wdata;
      // Denominator is only staged; it waits for the numerator
      if (denom_done && denom_raw >= `DPS_MIN_POS32 && denom_raw <= `DPS_MAX_POS32)
        denom_stage_q <= denom_raw;
      if (num_ok)
      begin
        scale_num_q <= num_raw;
        scale_denom_q <= denom_stage_q;
      end
    end
  end

  // Direction latched once after power-up only
  always @(posedge clk)
  begin
    if (reset)
    begin
      dir_ccw_q <= 1'b0;
      init_q <= 1'b1;
    end
    else
    begin
      // Direction follows power-up only, never a write in run
      init_q <= num_ok;
      if (init_q && !factor_valid_q)
        dir_ccw_q <= dir_q[0];
    end
  end

  // Factor in revolutions per user unit, 15 fraction bits
  always @(posedge clk)
  begin
    if (reset)
    begin
      scale_factor_q <= 47'h0;
      factor_valid_q <= 1'b0;
      user_limit_q <= `DPS_MAX_POS32;
    end
    else
    begin
      // Users must wait for valid; the old factor is stale once init fires
      if (init_q)
        factor_valid_q <= 1'b0;
      if (div_done)
      begin
        scale_factor_q <= quot;
        factor_valid_q <= 1'b1;
        // Large factors shrink the representable user range
        if (quot[46:`DPS_LIMIT_BIT] != 15'h0000)
          user_limit_q <= `DPS_MAX_POS32 >> 1;
        else
          user_limit_q <= `DPS_MAX_POS32;
      end
    end
  end

  // Effective speed, clamped to the limit, never below minimum
  always @(posedge clk)
  begin
    if (reset)
    begin
      pp_speed_eff_q <= `DPS_RST_PPSPD;
      rel_ref_actual_q <= 1'b0;
    end
    else
    begin
      // Option 1 never reaches opt_q, so only 0 and 2 occur here
      rel_ref_actual_q <= (opt_q == `DPS_OPT_ACT);
      if (spd_raw > {16'h0000, nmax_q})
        pp_speed_eff_q <= {16'h0000, nmax_q};
      else if (spd_raw < `DPS_MIN_SPD)
        pp_speed_eff_q <= `DPS_MIN_SPD;
      else
        pp_speed_eff_q <= spd_raw;
    end
  end
endmodule // dps_params

// File: verilog/dps_regs.vh
// Register map, reset values and limits of the position scaling parameter block.
// Assumes 16-bit fieldbus register addresses; 32-bit values occupy two addresses.
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

`define DPS_ADDR_DENOM 16'h060E
`define DPS_ADDR_NUM 16'h0610
`define DPS_ADDR_DIR 16'h0618
`define DPS_ADDR_PPSPD 16'h1B1E
`define DPS_ADDR_PPOPT 16'h1B30
`define DPS_ADDR_NMAX 16'h0612

`define DPS_RST_DENOM 32'h00004000
`define DPS_RST_NUM 32'h00000001
`define DPS_RST_DIR 16'h0000
`define DPS_RST_PPSPD 32'h0000003C
`define DPS_RST_PPOPT 16'h0000
`define DPS_RST_NMAX 16'h0BB8

`define DPS_MIN_POS32 32'h00000001
`define DPS_MAX_POS32 32'h7FFFFFFF
`define DPS_MIN_SPD 32'h00000001
`define DPS_OPT_PREV 16'h0000
`define DPS_OPT_UNSUP 16'h0001
`define DPS_OPT_ACT 16'h0002
`define DPS_DIR_MAX 16'h0001

`define DPS_FACTOR_SHIFT 5'h0F
`define DPS_LIMIT_BIT 6'h20
`define DPS_DIV_STEPS 6'h2F

`endif

// File: verilog/dps_scale_div.v
// Serial divider computing (num << shift) / denom for the scaling factor.
// Assumes start only while idle; takes 47 cycles.
`timescale 1ns/10ps
`include "dps_regs.vh"
module dps_scale_div
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Operands
  input wire start,
  input wire [46:0] dividend,
  input wire [31:0] divisor,
  // Result
  output reg [46:0] quot_q,
  output reg busy_q,
  output reg done_q
);
  reg [46:0] shf_q;
  reg [32:0] rem_q;
  reg [5:0] cnt_q;
  wire [32:0] trial;

  assign trial = {rem_q[31:0], shf_q[46]} - {1'b0, divisor};

  always @(posedge clk)
  begin
    if (reset)
    begin
      shf_q <= 47'h0;
      rem_q <= 33'h0;
      cnt_q <= 6'h00;
      quot_q <= 47'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start && !busy_q)
      begin
        shf_q <= dividend;
        rem_q <= 33'h0;
        cnt_q <= `DPS_DIV_STEPS;
        busy_q <= 1'b1;
      end
      else if (busy_q)
      begin
        if (!trial[32])
        begin
          rem_q <= trial;
          shf_q <= {shf_q[45:0], 1'b1};
        end
        else
        begin
          rem_q <= {rem_q[31:0], shf_q[46]};
          shf_q <= {shf_q[45:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01)
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          quot_q <= (!trial[32]) ? {shf_q[45:0], 1'b1} : {shf_q[45:0], 1'b0};
        end
      end
    end
  end
endmodule // dps_scale_div

// File: verilog/dps_word_pair.v
// Holds one 32-bit parameter written as two 16-bit halves.
// Assumes high half at the base address, low half at base + 1.
`timescale 1ns/10ps
module dps_word_pair
#(
  parameter [15:0] BASE = 16'h0000,
  parameter [31:0] RST = 32'h00000000
)
(
  // Clock and reset
  input wire clk,
  input wire reset,
  // Write strobe
  input wire wr,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  // Value and commit pulse
  output reg [31:0] value_q,
  output reg done_q
);
  reg [15:0] hi_q;
  reg hi_ok_q;

  always @(posedge clk)
  begin
    if (reset)
    begin
      hi_q <= 16'h0000;
      hi_ok_q <= 1'b0;
      value_q <= RST;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (wr && addr == BASE)
      begin
        hi_q <= wdata;
        hi_ok_q <= 1'b1;
      end
      else if (wr && addr == BASE + 16'h0001 && hi_ok_q)
      begin
        // Both halves land together, never half an update
        value_q <= {hi_q, wdata};
        hi_ok_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule // dps_word_pair
